/* File: logic/dbuart_params.svh */
`ifndef DBUART_PARAMS_SVH
`define DBUART_PARAMS_SVH

// Register byte offsets
`define DBUART_OFS_COMMAND      8'h00
`define DBUART_OFS_LINE_MODE    8'h04
`define DBUART_OFS_IRQ_ENABLE   8'h08
`define DBUART_OFS_IRQ_DISABLE  8'h0C
`define DBUART_OFS_IRQ_MASK     8'h10
`define DBUART_OFS_STATE_FLAGS  8'h14
`define DBUART_OFS_RX_HOLDING   8'h18
`define DBUART_OFS_TX_HOLDING   8'h1C
`define DBUART_OFS_BIT_RATE     8'h20
`define DBUART_OFS_CHIP_IDENT   8'h40
`define DBUART_OFS_IDENT_EXT    8'h44
`define DBUART_OFS_TEST_BLOCK   8'h48

// Command register bit positions
`define DBUART_CMD_RX_RESET     2
`define DBUART_CMD_TX_RESET     3
`define DBUART_CMD_RX_ENABLE    4
`define DBUART_CMD_RX_DISABLE   5
`define DBUART_CMD_TX_ENABLE    6
`define DBUART_CMD_TX_DISABLE   7
`define DBUART_CMD_CLEAR_ERR    8

// Line mode fields
`define DBUART_MODE_PAR_LSB     9
`define DBUART_MODE_PAR_MSB     11
`define DBUART_MODE_CHM_LSB     14
`define DBUART_MODE_CHM_MSB     15

// Status and interrupt bit positions
`define DBUART_ST_RX_READY      0
`define DBUART_ST_TX_READY      1
`define DBUART_ST_OVERRUN       5
`define DBUART_ST_FRAMING       6
`define DBUART_ST_PARITY        7
`define DBUART_ST_TX_EMPTY      9
`define DBUART_ST_CHAN_TX       30
`define DBUART_ST_CHAN_RX       31

// Identification and test port blocking
`define DBUART_CID_EXT_BIT      31
`define DBUART_FORCE_TRST_BIT   0

// Reset values and interrupt-capable status bits
`define DBUART_MODE_RESET       32'h0000_0000
`define DBUART_MASK_RESET       32'h0000_0000
`define DBUART_DIVISOR_RESET    16'h0000
`define DBUART_IRQ_BITS         32'hC000_02E3

`endif

/* File: logic/dbuart_pkg.sv */
package dbuart_pkg;

   typedef enum logic [1:0] {
      CHM_NORMAL      = 2'b00,
      CHM_AUTO_ECHO   = 2'b01,
      CHM_LOCAL_LOOP  = 2'b10,
      CHM_REMOTE_LOOP = 2'b11
   } dbuart_channel_mode_type;

   typedef enum logic [2:0] {
      PAR_EVEN  = 3'b000,
      PAR_ODD   = 3'b001,
      PAR_SPACE = 3'b010,
      PAR_MARK  = 3'b011,
      PAR_NONE  = 3'b100
   } dbuart_parity_type;

endpackage

/* File: logic/dbuart_ctrl.sv */
`timescale 1ns/100ps
`include "dbuart_params.svh"
// Summary of operation
// - Channel pending flags are status bits 31, 30
// - Channel flags can raise the interrupt
// - Identification registers are fixed and read-only
// - Identification word carries the documented fields
// - Extension reads zero when extension bit clear
// - Force bit holds test port reset asserted
// - Force bit is cleared by reset
// - Bit 2 resets and disables receiver immediately
// - Bit 3 resets and disables transmitter immediately
// - Bit 4 enables receiver unless bit 5 set
// - Bit 5 disables receiver after current character
// - Bit 6 enables transmitter unless bit 7 set
// - Bit 7 disables transmitter after queued characters
// - Bit 8 clears parity, framing, overrun flags
// - Parity field selects even, odd, space, mark, none
// - Channel field selects normal, echo, local, remote
// - Loopback modes route pins as described
// - Echo mode copies receive pin to transmit pin
module dbuart_ctrl #(
   parameter logic [31:0] CHIP_IDENT_VALUE = 32'h8000_0000, // Arbitrary value
   parameter logic [31:0] IDENT_EXT_VALUE  = 32'h0000_0001, // Arbitrary value
   parameter int          DIVISOR_WIDTH    = 16
) (
   // Clock, reset, enable
   input  wire logic                          hclk,
   input  wire logic                          hresetn,
   input  wire logic                          clk_en,
   // AHB-Lite slave
   input  wire logic                          hsel,
   input  wire logic [7:0]                    haddr,
   input  wire logic [1:0]                    htrans,
   input  wire logic                          hwrite,
   input  wire logic [2:0]                    hsize,
   input  wire logic [31:0]                   hwdata,
   input  wire logic                          hready,
   output logic      [31:0]                   hrdata,
   output logic                               hreadyout,
   output logic                               hresp,
   // Processor debug channel
   input  wire logic                          dbg_chan_rx_pending,
   input  wire logic                          dbg_chan_tx_pending,
   // Receiver core
   input  wire logic                          rx_busy,
   input  wire logic                          rx_char_ready,
   input  wire logic [7:0]                    rx_char,
   input  wire logic                          rx_parity_err_evt,
   input  wire logic                          rx_framing_err_evt,
   input  wire logic                          rx_overrun_err_evt,
   output logic                               rx_enable,
   output logic                               rx_core_reset,
   output logic                               rx_core_in,
   // Transmitter core
   input  wire logic                          tx_busy,
   input  wire logic                          tx_holding_full,
   input  wire logic                          tx_core_out,
   output logic                               tx_enable,
   output logic                               tx_core_reset,
   output logic      [7:0]                    tx_char,
   output logic                               tx_char_load,
   output dbuart_pkg::dbuart_parity_type      parity_type,
   output logic      [DIVISOR_WIDTH-1:0]      bit_rate_divisor,
   // Pins and system
   input  wire logic                          serial_rx_pin,
   output logic                               serial_tx_pin,
   output logic                               test_port_reset_n,
   output logic                               irq
);
   import dbuart_pkg::*;

   // Bus phase state
   logic                     wr_pend_reg;
   logic                     rd_pend_reg;
   logic [7:0]               addr_reg;
   logic [31:0]              hrdata_reg;
   logic                     hreadyout_reg;
   // Control state
   logic [31:0]              mode_reg;
   logic [31:0]              mask_reg;
   logic [DIVISOR_WIDTH-1:0] divisor_reg;
   logic                     force_trst_reg;
   logic                     rx_en_reg;
   logic                     rx_stop_reg;
   logic                     tx_en_reg;
   logic                     tx_stop_reg;
   logic                     rx_rst_reg;
   logic                     tx_rst_reg;
   logic                     par_err_reg;
   logic                     frm_err_reg;
   logic                     ovr_err_reg;
   logic [7:0]               tx_char_reg;
   logic                     tx_load_reg;
   logic                     tx_pin_reg;
   logic                     rx_in_reg;
   logic                     irq_reg;
   logic                     tport_n_reg;
   dbuart_parity_type        parity_reg;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   // Address phase and write decode
   wire        addr_phase = hsel && htrans[1] && hready;
   wire        wr_now     = wr_pend_reg;
   wire        wr_cmd     = wr_now && hit(addr_reg, `DBUART_OFS_COMMAND);
   wire        wr_mode    = wr_now && hit(addr_reg, `DBUART_OFS_LINE_MODE);
   wire        wr_ier     = wr_now && hit(addr_reg, `DBUART_OFS_IRQ_ENABLE);
   wire        wr_idr     = wr_now && hit(addr_reg, `DBUART_OFS_IRQ_DISABLE);
   wire        wr_thr     = wr_now && hit(addr_reg, `DBUART_OFS_TX_HOLDING);
   wire        wr_brg     = wr_now && hit(addr_reg, `DBUART_OFS_BIT_RATE);
   wire        wr_fnr     = wr_now && hit(addr_reg, `DBUART_OFS_TEST_BLOCK);

   // Command bits; a zero bit never qualifies
   wire        c_rx_rst   = wr_cmd && hwdata[`DBUART_CMD_RX_RESET];
   wire        c_tx_rst   = wr_cmd && hwdata[`DBUART_CMD_TX_RESET];
   wire        c_rx_dis   = wr_cmd && hwdata[`DBUART_CMD_RX_DISABLE];
   wire        c_tx_dis   = wr_cmd && hwdata[`DBUART_CMD_TX_DISABLE];
   wire        c_rx_en    = wr_cmd && hwdata[`DBUART_CMD_RX_ENABLE] && !c_rx_dis;
   wire        c_tx_en    = wr_cmd && hwdata[`DBUART_CMD_TX_ENABLE] && !c_tx_dis;
   wire        c_clr_err  = wr_cmd && hwdata[`DBUART_CMD_CLEAR_ERR];

   dbuart_channel_mode_type channel_mode;
   assign channel_mode = dbuart_channel_mode_type'(mode_reg[`DBUART_MODE_CHM_MSB:`DBUART_MODE_CHM_LSB]);
   // Decoded as written so the output leaves a flop
   wire [2:0] par_field = hwdata[`DBUART_MODE_PAR_MSB:`DBUART_MODE_PAR_LSB];
   // Top bit set means no parity whatever the low bits hold
   dbuart_parity_type parity_next;
   assign parity_next = par_field[2] ? PAR_NONE : dbuart_parity_type'(par_field);

   // Receiver stops at once when idle, otherwise after the character
   wire        rx_en_next   = c_rx_rst ? 1'b0 :
                              c_rx_en ? 1'b1 :
                              (rx_stop_reg || c_rx_dis) && !rx_busy ? 1'b0 : rx_en_reg;
   wire        rx_stop_next = !(c_rx_rst || c_rx_en) && rx_en_next &&
                              (rx_stop_reg || c_rx_dis);
   // Transmitter drains shifter and holding register first
   wire        tx_idle      = !tx_busy && !tx_holding_full;
   wire        tx_en_next   = c_tx_rst ? 1'b0 :
                              c_tx_en ? 1'b1 :
                              (tx_stop_reg || c_tx_dis) && tx_idle ? 1'b0 : tx_en_reg;
   wire        tx_stop_next = !(c_tx_rst || c_tx_en) && tx_en_next &&
                              (tx_stop_reg || c_tx_dis);

   // Sticky errors: a new event wins over a simultaneous clear
   wire        par_next = (par_err_reg && !c_clr_err) || rx_parity_err_evt;
   wire        frm_next = (frm_err_reg && !c_clr_err) || rx_framing_err_evt;
   wire        ovr_next = (ovr_err_reg && !c_clr_err) || rx_overrun_err_evt;

   // Status word, channel flags on the top two bits
   wire [31:0] status_word = {dbg_chan_rx_pending, dbg_chan_tx_pending, 20'h0_0000,
                              tx_en_reg && tx_idle, 1'b0, par_err_reg, frm_err_reg,
                              ovr_err_reg, 3'b000, tx_en_reg && !tx_holding_full,
                              rx_char_ready};
   wire [31:0] mask_next = wr_ier ? (mask_reg | (hwdata & `DBUART_IRQ_BITS)) :
                           wr_idr ? (mask_reg & ~hwdata) : mask_reg;
   // Any enabled status bit, channel flags included, drives the line
   wire        irq_next  = |(status_word & mask_reg);

   // Extension reads zero unless flagged in the ident word
   wire [31:0] ext_word  = CHIP_IDENT_VALUE[`DBUART_CID_EXT_BIT] ? IDENT_EXT_VALUE : 32'h0;

   // Read mux; write-only and reserved offsets read zero
   wire [31:0] rd_word =
      hit(addr_reg, `DBUART_OFS_LINE_MODE)   ? mode_reg :
      hit(addr_reg, `DBUART_OFS_IRQ_MASK)    ? mask_reg :
      hit(addr_reg, `DBUART_OFS_STATE_FLAGS) ? status_word :
      hit(addr_reg, `DBUART_OFS_RX_HOLDING)  ? {24'h00_0000, rx_char} :
      hit(addr_reg, `DBUART_OFS_BIT_RATE)    ? 32'(divisor_reg) :
      hit(addr_reg, `DBUART_OFS_CHIP_IDENT)  ? CHIP_IDENT_VALUE :
      hit(addr_reg, `DBUART_OFS_IDENT_EXT)   ? ext_word :
      hit(addr_reg, `DBUART_OFS_TEST_BLOCK)  ? {31'h0, force_trst_reg} : 32'h0;

   // Pin routing per channel mode
   logic tx_pin_next;
   logic rx_in_next;
   always_comb begin
      unique case (channel_mode)
         CHM_NORMAL: begin
            tx_pin_next = tx_core_out;
            rx_in_next  = serial_rx_pin;
         end
         CHM_AUTO_ECHO: begin
            tx_pin_next = serial_rx_pin;
            rx_in_next  = serial_rx_pin;
         end
         CHM_LOCAL_LOOP: begin
            tx_pin_next = 1'b1;
            rx_in_next  = tx_core_out;
         end
         CHM_REMOTE_LOOP: begin
            tx_pin_next = serial_rx_pin;
            rx_in_next  = 1'b1;
         end
      endcase
   end

   // Bus phase tracking; reads take one wait state so prior writes land
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg   <= 1'b0;
         rd_pend_reg   <= 1'b0;
         addr_reg      <= 8'h00;
         hrdata_reg    <= 32'h0000_0000;
         hreadyout_reg <= 1'b1;
      end else if (clk_en) begin
         wr_pend_reg   <= addr_phase && hwrite;
         rd_pend_reg   <= addr_phase && !hwrite;
         hreadyout_reg <= !(addr_phase && !hwrite);
         if (addr_phase) begin
            addr_reg <= {haddr[7:2], 2'b00};
         end
         if (rd_pend_reg) begin
            hrdata_reg <= rd_word;
         end
      end
   end

   // Software-written configuration
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_reg       <= `DBUART_MODE_RESET;
         mask_reg       <= `DBUART_MASK_RESET;
         divisor_reg    <= `DBUART_DIVISOR_RESET;
         force_trst_reg <= 1'b0;
         tport_n_reg    <= 1'b1;
         parity_reg     <= PAR_EVEN;
         tx_char_reg    <= 8'h00;
         tx_load_reg    <= 1'b0;
      end else if (clk_en) begin
         mask_reg    <= mask_next;
         tx_load_reg <= wr_thr;
         if (wr_mode) begin
            mode_reg <= hwdata & 32'h0000_CE00;
            parity_reg <= parity_next;
         end
         if (wr_brg) begin
            divisor_reg <= hwdata[DIVISOR_WIDTH-1:0];
         end
         if (wr_fnr) begin
            force_trst_reg <= hwdata[`DBUART_FORCE_TRST_BIT];
            tport_n_reg    <= !hwdata[`DBUART_FORCE_TRST_BIT];
         end
         if (wr_thr) begin
            tx_char_reg <= hwdata[7:0];
         end
      end
   end

   // Enable, stop and error state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_en_reg   <= 1'b0;
         rx_stop_reg <= 1'b0;
         tx_en_reg   <= 1'b0;
         tx_stop_reg <= 1'b0;
         rx_rst_reg  <= 1'b0;
         tx_rst_reg  <= 1'b0;
         par_err_reg <= 1'b0;
         frm_err_reg <= 1'b0;
         ovr_err_reg <= 1'b0;
      end else if (clk_en) begin
         rx_en_reg   <= rx_en_next;
         rx_stop_reg <= rx_stop_next;
         tx_en_reg   <= tx_en_next;
         tx_stop_reg <= tx_stop_next;
         rx_rst_reg  <= c_rx_rst;
         tx_rst_reg  <= c_tx_rst;
         par_err_reg <= par_next;
         frm_err_reg <= frm_next;
         ovr_err_reg <= ovr_next;
      end
   end

   // Registered pins and interrupt line
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_pin_reg <= 1'b1;
         rx_in_reg  <= 1'b1;
         irq_reg    <= 1'b0;
      end else if (clk_en) begin
         tx_pin_reg <= tx_pin_next;
         rx_in_reg  <= rx_in_next;
         irq_reg    <= irq_next;
      end
   end

   assign hrdata            = hrdata_reg;
   assign hreadyout         = hreadyout_reg;
   assign hresp             = 1'b0;
   // Remote loopback leaves the enables alone; the receiver just sees an idle line
   assign rx_enable         = rx_en_reg;
   assign tx_enable         = tx_en_reg;
   assign rx_core_reset     = rx_rst_reg;
   assign tx_core_reset     = tx_rst_reg;
   assign tx_char           = tx_char_reg;
   assign tx_char_load      = tx_load_reg;
   assign bit_rate_divisor  = divisor_reg;
   assign serial_tx_pin     = tx_pin_reg;
   assign rx_core_in        = rx_in_reg;
   assign test_port_reset_n = tport_n_reg;
   assign parity_type       = parity_reg;
   assign irq               = irq_reg;

   // Checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   AST_CHAN_FLAGS: assert property (clk_en && rd_pend_reg &&
         hit(addr_reg, `DBUART_OFS_STATE_FLAGS) |=>
         hrdata[31] == $past(dbg_chan_rx_pending) &&
         hrdata[30] == $past(dbg_chan_tx_pending))
      else $error("Channel flags not on status bits 31 and 30");
   AST_CHAN_IRQ: assert property (clk_en && mask_reg[31] && dbg_chan_rx_pending |=> irq)
      else $error("Enabled channel flag did not raise interrupt");
   AST_CHAN_TX_IRQ: assert property (clk_en && mask_reg[30] &&
         dbg_chan_tx_pending |=> irq)
      else $error("Enabled transmit channel flag did not raise interrupt");
   AST_IDENT_FIXED: assert property (clk_en && rd_pend_reg &&
         hit(addr_reg, `DBUART_OFS_CHIP_IDENT) |=> hrdata == CHIP_IDENT_VALUE)
      else $error("Identification word changed");
   AST_EXT_ZERO: assert property (clk_en && rd_pend_reg &&
         hit(addr_reg, `DBUART_OFS_IDENT_EXT) && !CHIP_IDENT_VALUE[`DBUART_CID_EXT_BIT]
         |=> hrdata == 32'h0)
      else $error("Extension read nonzero without extension bit");
   AST_WO_READ: assert property (clk_en && rd_pend_reg &&
         hit(addr_reg, `DBUART_OFS_TX_HOLDING) |=> hrdata == 32'h0)
      else $error("Write-only register read nonzero");
   AST_READ_WAIT: assert property (clk_en && addr_phase && !hwrite |=> !hreadyout)
      else $error("Read address phase not followed by a wait state");
   AST_FORCE_TRST: assert property (clk_en && wr_fnr && hwdata[0] |=>
         !test_port_reset_n)
      else $error("Test port reset not asserted after force write");
   AST_FORCE_HOLD: assert property (clk_en && !wr_fnr |=>
         $stable(test_port_reset_n))
      else $error("Test port reset changed without a force write");
   AST_RX_RESET: assert property (clk_en && c_rx_rst |=> !rx_enable && rx_core_reset)
      else $error("Receiver reset did not disable at once");
   AST_TX_RESET: assert property (clk_en && c_tx_rst |=> !tx_enable && tx_core_reset)
      else $error("Transmitter reset did not disable at once");
   AST_RX_EN_PRIO: assert property (clk_en && wr_cmd && hwdata[5:4] == 2'b11 &&
         !rx_en_reg |=> !rx_enable)
      else $error("Receiver enabled despite disable in same write");
   AST_RX_DRAIN: assert property (clk_en && c_rx_dis && !c_rx_rst && rx_en_reg &&
         rx_busy |=> rx_enable)
      else $error("Receiver stopped mid character");
   AST_TX_DRAIN: assert property (clk_en && c_tx_dis && !c_tx_rst && tx_en_reg &&
         !tx_idle |=> tx_enable)
      else $error("Transmitter stopped with characters queued");
   AST_TX_EN: assert property (clk_en && c_tx_en |=> tx_enable)
      else $error("Transmitter enable ignored");
   AST_ERR_CLEAR: assert property (clk_en && c_clr_err && !rx_parity_err_evt |=>
         !status_word[`DBUART_ST_PARITY])
      else $error("Parity flag not cleared");
   AST_LOCAL_LOOP: assert property (clk_en && channel_mode == CHM_LOCAL_LOOP |=> serial_tx_pin)
      else $error("Transmit pin not idle in local loopback");
   AST_REMOTE_LOOP: assert property (clk_en && channel_mode == CHM_REMOTE_LOOP |=>
         serial_tx_pin == $past(serial_rx_pin) && rx_core_in)
      else $error("Remote loopback did not route receive pin");
   AST_ECHO: assert property (clk_en && channel_mode == CHM_AUTO_ECHO |=>
         serial_tx_pin == $past(serial_rx_pin))
      else $error("Echo mode did not copy receive pin");

   COV_RX_DRAIN: cover property (c_rx_dis && rx_busy ##[1:20] !rx_enable);
   COV_CHAN_IRQ: cover property (dbg_chan_tx_pending && mask_reg[30] ##1 irq);
   COV_FORCE:    cover property (wr_fnr ##1 !test_port_reset_n);
   COV_REMOTE:   cover property (channel_mode == CHM_REMOTE_LOOP ##1 serial_tx_pin == 1'b0);
   COV_ECHO:     cover property (channel_mode == CHM_AUTO_ECHO ##1 serial_tx_pin == 1'b0);

endmodule // dbuart_ctrl

/* File: verif/dbuart_host_model.sv */
`timescale 1ns/100ps
module dbuart_host_model (
   // Clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // Frame request from the bench
   input  wire logic       start,
   input  wire logic [7:0] char_in,
   // Serial line
   input  wire logic       serial_tx_pin,
   output logic            serial_rx_pin
);
   logic [9:0] frame_reg;
   // One bit per clock keeps frames short; the line idles high as a pull-up would hold it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         frame_reg <= 10'h3FF;
      end else if (start) begin
         frame_reg <= {1'b1, char_in, 1'b0};
      end else begin
         frame_reg <= {1'b1, frame_reg[9:1]};
      end
   end
   assign serial_rx_pin = frame_reg[0];
endmodule // dbuart_host_model

/* File: verif/dbuart_ctrl_tb.sv */
`timescale 1ns/100ps
module dbuart_ctrl_tb;
   import dbuart_pkg::*;
   logic        hclk = 1'b0, hresetn = 1'b0, clk_en = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [7:0]  haddr = 8'h00, rx_char = 8'h00, host_char = 8'h00, tx_char;
   logic [1:0]  htrans = 2'h0, cm;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0, hrdata, rd_q, d;
   logic        dbg_chan_rx_pending = 1'b0, dbg_chan_tx_pending = 1'b0, rx_busy = 1'b0;
   logic        rx_char_ready = 1'b0, tx_busy = 1'b0, tx_holding_full = 1'b0, tx_core_out = 1'b1;
   logic        rx_parity_err_evt = 1'b0, rx_framing_err_evt = 1'b0, rx_overrun_err_evt = 1'b0;
   logic        host_start = 1'b0, rp, tp, hreadyout, hresp, rx_enable, rx_core_reset, rx_core_in;
   logic        tx_enable, tx_core_reset, tx_char_load, serial_rx_pin, serial_tx_pin;
   logic        test_port_reset_n, irq;
   logic [15:0] bit_rate_divisor;
   dbuart_parity_type parity_type;
   wire         hready = hreadyout;
   int          errors = 0, n_checks = 0, i, k;
   int unsigned seed;
   logic [7:0]  ro_a [8] = '{8'h00, 8'h08, 8'h0C, 8'h1C, 8'h24, 8'h3C, 8'h4C, 8'hFC};

   dbuart_ctrl dut_u (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready, .hrdata, .hreadyout, .hresp, .dbg_chan_rx_pending,
      .dbg_chan_tx_pending, .rx_busy, .rx_char_ready, .rx_char, .rx_parity_err_evt,
      .rx_framing_err_evt, .rx_overrun_err_evt, .rx_enable, .rx_core_reset, .rx_core_in,
      .tx_busy, .tx_holding_full, .tx_core_out, .tx_enable, .tx_core_reset, .tx_char,
      .tx_char_load, .parity_type, .bit_rate_divisor, .serial_rx_pin, .serial_tx_pin,
      .test_port_reset_n, .irq);
   dbuart_host_model host_u (.hclk, .hresetn, .start(host_start), .char_in(host_char),
      .serial_tx_pin, .serial_rx_pin);

   always #2 hclk = ~hclk;

   function automatic logic [2:0] exp_par(input logic [2:0] v);
      return v[2] ? 3'h4 : v;
   endfunction
   function automatic logic exp_tx(input logic [1:0] m, input logic r, input logic t);
      return (m == 2'b00) ? t : ((m == 2'b10) ? 1'b1 : r);
   endfunction
   function automatic logic exp_rc(input logic [1:0] m, input logic r, input logic t);
      return (m == 2'b10) ? t : ((m == 2'b11) ? 1'b1 : r);
   endfunction

   task check(input string n, input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   // Hready is sampled at the falling edge so the bus never races the slave's own update
   task wait_rdy;
      do begin
         @(negedge hclk);
         rd_q = hrdata;
      end while (hreadyout !== 1'b1);
      @(posedge hclk);
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= v;
      wait_rdy;
   endtask
   task rdc(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      check(n, rd_q & m, e);
   endtask
   task cmd(input logic [31:0] v, input logic rb, input logic tb, input logic hf);
      @(posedge hclk);
      rx_busy <= rb;
      tx_busy <= tb;
      tx_holding_full <= hf;
      bus(1'b1, 8'h00, v);
      @(negedge hclk);
   endtask
   task wait_irq(input logic v);
      for (int j = 0; j < 6 && irq !== v; j++) @(negedge hclk);
      check("irq", irq, v);
   endtask
   task end_of_test;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      #200000;
      errors++;
      end_of_test;
   end

   initial begin
      seed = $urandom(67321);
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      {rx_char_ready, rx_char} <= 9'($urandom);
      @(negedge hclk);
      check("tport_n", test_port_reset_n, 1'b1);
      rdc("fnr", 8'h48, 32'hFFFF_FFFF, 32'h0);
      rdc("mode", 8'h04, 32'hFFFF_FFFF, 32'h0);
      rdc("rhr", 8'h18, 32'hFFFF_FFFF, {24'h0, rx_char});
      rdc("rxrdy", 8'h14, 32'h1, {31'h0, rx_char_ready});
      for (i = 0; i < 2; i++) begin
         rdc("cid", 8'h40, 32'hFFFF_FFFF, 32'h8000_0000);
         rdc("exid", 8'h44, 32'hFFFF_FFFF, 32'h1);
         bus(1'b1, 8'h40, $urandom);
         bus(1'b1, 8'h44, $urandom);
      end
      for (i = 0; i < 8; i++) begin
         if (i > 3) bus(1'b1, ro_a[i], $urandom);
         rdc("unread", ro_a[i], 32'hFFFF_FFFF, 32'h0);
      end
      bus(1'b1, 8'h04, 32'hFFFF_FFFF);
      rdc("mode_rsv", 8'h04, 32'hFFFF_FFFF, 32'h0000_CE00);
      for (i = 0; i < 8; i++) begin
         bus(1'b1, 8'h04, {20'h0, 3'(i), 9'h0});
         @(negedge hclk);
         check("parity", parity_type, exp_par(3'(i)));
      end
      for (i = 0; i < 4; i++) begin
         @(posedge hclk);
         cm = 2'($urandom);
         {dbg_chan_rx_pending, dbg_chan_tx_pending} <= cm;
         rdc("chan", 8'h14, 32'hC000_0000, {cm, 30'h0});
      end
      {dbg_chan_rx_pending, dbg_chan_tx_pending} <= 2'h0;
      bus(1'b1, 8'h08, 32'hC000_0000);
      rdc("mask", 8'h10, 32'hFFFF_FFFF, 32'hC000_0000);
      wait_irq(1'b0);
      @(posedge hclk);
      dbg_chan_tx_pending <= 1'b1;
      wait_irq(1'b1);
      bus(1'b1, 8'h0C, 32'h4000_0000);
      wait_irq(1'b0);
      @(posedge hclk);
      dbg_chan_rx_pending <= 1'b1;
      wait_irq(1'b1);
      @(posedge hclk);
      dbg_chan_rx_pending <= 1'b0;
      wait_irq(1'b0);
      bus(1'b1, 8'h48, 32'hFFFF_FFFF);
      @(negedge hclk);
      check("tport_n", test_port_reset_n, 1'b0);
      rdc("fnr", 8'h48, 32'hFFFF_FFFF, 32'h1);
      bus(1'b1, 8'h48, 32'h0);
      @(negedge hclk);
      check("tport_n", test_port_reset_n, 1'b1);
      cmd(32'h10, 0, 0, 0);
      check("rx_en", rx_enable, 1'b1);
      cmd(32'h30, 0, 0, 0);
      check("rx_en", rx_enable, 1'b0);
      cmd(32'h10, 1, 0, 0);
      cmd(32'h20, 1, 0, 0);
      check("rx_en", rx_enable, 1'b1);
      cmd(32'h0, 0, 0, 0);
      check("rx_en", rx_enable, 1'b0);
      cmd(32'h10, 1, 0, 0);
      cmd(32'h0, 1, 0, 0);
      check("rx_en", rx_enable, 1'b1);
      cmd(32'h4, 1, 0, 0);
      check("rx_rst", {rx_core_reset, rx_enable}, 2'b10);
      cmd(32'h40, 0, 0, 1);
      check("tx_en", tx_enable, 1'b1);
      cmd(32'h80, 0, 0, 1);
      check("tx_en", tx_enable, 1'b1);
      cmd(32'h0, 0, 1, 0);
      check("tx_en", tx_enable, 1'b1);
      cmd(32'h0, 0, 0, 0);
      check("tx_en", tx_enable, 1'b0);
      cmd(32'hC0, 0, 0, 0);
      check("tx_en", tx_enable, 1'b0);
      cmd(32'h40, 0, 1, 1);
      cmd(32'h8, 0, 1, 1);
      check("tx_rst", {tx_core_reset, tx_enable}, 2'b10);
      @(posedge hclk);
      {rx_parity_err_evt, rx_framing_err_evt, rx_overrun_err_evt} <= 3'h7;
      @(posedge hclk);
      {rx_parity_err_evt, rx_framing_err_evt, rx_overrun_err_evt} <= 3'h0;
      rdc("errs", 8'h14, 32'hE0, 32'hE0);
      cmd(32'h0, 0, 0, 0);
      rdc("errs", 8'h14, 32'hE0, 32'hE0);
      cmd(32'h100, 0, 0, 0);
      rdc("errs", 8'h14, 32'hE0, 32'h0);
      d = $urandom;
      bus(1'b1, 8'h20, d);
      rdc("div", 8'h20, 32'hFFFF_FFFF, {16'h0, d[15:0]});
      check("div_out", bit_rate_divisor, d[15:0]);
      bus(1'b1, 8'h1C, d);
      @(negedge hclk);
      check("thr", {tx_char_load, tx_char}, {1'b1, d[7:0]});
      for (i = 0; i < 4; i++) begin
         cm = 2'(i);
         bus(1'b1, 8'h04, {16'h0, cm, 2'b00, 3'($urandom), 9'h0});
         for (k = 0; k < 12; k++) begin
            @(posedge hclk);
            tx_core_out <= 1'($urandom);
            host_start <= (k == 0);
            host_char <= 8'($urandom);
            @(negedge hclk);
            if (k > 0) begin
               check("tx_pin", serial_tx_pin, exp_tx(cm, rp, tp));
               check("rx_core", rx_core_in, exp_rc(cm, rp, tp));
            end
            rp = serial_rx_pin;
            tp = tx_core_out;
         end
      end
      check("hresp", hresp, 1'b0);
      end_of_test;
   end
endmodule // dbuart_ctrl_tb
